/* File: common/sac_pkg.sv */
// Package of constants and types for the converter control block
package sac_pkg;

    // ****************************************************************
    // Register map (byte addresses on the 32-bit APB bus)
    // ****************************************************************
    localparam logic [11:0] SAC_ADDR_PORT   = 12'h004;   // Pin read-back, masked
    localparam logic [11:0] SAC_ADDR_MAIN   = 12'h008;   // converter_control_main
    localparam logic [11:0] SAC_ADDR_RESULT = 12'h00C;   // conversion_result
    localparam logic [11:0] SAC_ADDR_CONFIG = 12'h088;   // converter_port_config

    // ****************************************************************
    // Field positions in converter_control_main and converter_port_config
    // ****************************************************************
    localparam int SAC_CLKSEL_HI = 7;   // conv_clock_select top bit
    localparam int SAC_CLKSEL_LO = 6;   // conv_clock_select low bit
    localparam int SAC_BIT5      = 5;   // Storage bit or channel top bit
    localparam int SAC_CHS_HI    = 4;   // channel_select top bit
    localparam int SAC_CHS_LO    = 3;   // channel_select low bit
    localparam int SAC_GO        = 2;   // Go flag
    localparam int SAC_FLAG      = 1;   // conversion_complete_flag
    localparam int SAC_ON        = 0;   // converter_on
    localparam int SAC_PCFG_HI   = 1;   // port_config_select top bit
    localparam int SAC_PCFG_LO   = 0;   // port_config_select low bit

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] SAC_MAIN_RST   = 8'h00;
    localparam logic [1:0] SAC_PCFG_RST   = 2'h0;
    localparam logic [7:0] SAC_RESULT_RST = 8'h00;

    // ****************************************************************
    // Conversion clock and timing counts, in half bit periods
    // ****************************************************************
    localparam logic [1:0] SAC_CLK_DIV2  = 2'h0;   // bit period 2 core clocks
    localparam logic [1:0] SAC_CLK_DIV8  = 2'h1;   // bit period 8 core clocks
    localparam logic [1:0] SAC_CLK_DIV32 = 2'h2;   // bit period 32 core clocks
    localparam logic [1:0] SAC_CLK_RC    = 2'h3;   // internal_rc_clock
    localparam logic [3:0] SAC_HALF_DIV2  = 4'h1;  // core clocks per half period
    localparam logic [3:0] SAC_HALF_DIV8  = 4'h4;
    localparam logic [3:0] SAC_HALF_DIV32 = 4'h0;  // 16 wraps to zero in 4 bits
    localparam logic [4:0] SAC_HALF_SETUP = 5'h03; // 1.5 periods before first bit
    localparam logic [4:0] SAC_HALF_CONV  = 5'h13; // 9.5 periods in all
    localparam logic [4:0] SAC_HALF_GAP   = 5'h04; // 2 periods after a conversion

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [1:0] {
        SAC_OFF  = 2'b00,   // Converter powered down
        SAC_ACQ  = 2'b01,   // Hold capacitor tracking the channel
        SAC_CONV = 2'b10,   // Successive approximation running
        SAC_GAP  = 2'b11    // Capacitor disconnected after a conversion
    } sac_state_t;

    // ****************************************************************
    // Analog front-end control carrier
    // ****************************************************************
    typedef struct packed {
        logic       power_on;     // Converter supplied
        logic       sample;       // Hold capacitor connected to the channel
        logic       ref_ext;      // Reference taken from pin 3
        logic [1:0] channel;      // Selected analog input
        logic [7:0] dac_code;     // Trial code for the comparator
        logic [3:0] analog_mask;  // Pins in analog use
    } sac_afe_t;

endpackage

/* File: design/sac_adc_ctrl.sv */
// Control logic of a four-channel 8-bit successive-approximation converter
//
// What this block does
// - Successive approximation yields 8-bit unsigned code
// - Conversion continues in sleep on RC clock
// - Bits 7-6 pick /2, /8, /32, RC
// - Bits 4-3 select analog input 0 to 3
// - Three-bit channel field ignores its top bit
// - Go write starts conversion, reads 1 meanwhile
// - Completion loads result, clears go, sets flag
// - Hardware sets completion flag, software clears it
// - Converter-on bit powers converter, off draws nothing
// - Bit 5 is storage or reads zero
// - Port configuration field selects analog pin use
// - Second register upper bits zero, reset zero
// - Two periods pass before next acquisition
// - Software clears flag before enabling interrupts
// - Full conversion lasts nine and half periods
// - Go cleared aborts, result kept, gap follows
// - Analog pins read zero from port register
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module sac_adc_ctrl #(
    parameter bit GP_BIT5  = 1'b1,  // Bit 5 is a storage bit
    parameter bit CHS_3BIT = 1'b0   // Bit 5 is the channel field top bit
) (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_reset,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Device state and analog side
    input  wire logic                 i_sleep,
    input  wire logic                 i_rc_half_tick,
    input  wire logic                 i_cmp_high,
    input  wire logic [3:0]           i_port_pins,
    // Front-end control and status
    output sac_pkg::sac_afe_t         o_afe,
    output logic                      o_complete_flag,
    output logic                      o_busy
);
    import sac_pkg::*;

    // ****************************************************************
    // Decode helpers
    // ****************************************************************

    // Pins in analog use for each port configuration code
    function automatic logic [3:0] analog_pins(input logic [1:0] pcfg);
        case (pcfg)
            2'h0:    analog_pins = 4'b1111;  // All four analog
            2'h1:    analog_pins = 4'b0111;  // Pin 3 is the reference
            2'h2:    analog_pins = 4'b0011;  // Pins 2-3 digital
            default: analog_pins = 4'b0000;  // All digital
        endcase
    endfunction

    // Core clocks per half bit period; zero means sixteen
    function automatic logic [3:0] half_div(input logic [1:0] sel);
        case (sel)
            SAC_CLK_DIV2: half_div = SAC_HALF_DIV2;
            SAC_CLK_DIV8: half_div = SAC_HALF_DIV8;
            default:      half_div = SAC_HALF_DIV32;
        endcase
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    logic [1:0]  clksel_r,  clksel_nxt;   // conv_clock_select
    logic        bit5_r,    bit5_nxt;     // Storage or channel top bit
    logic [1:0]  chs_r,     chs_nxt;      // channel_select, low two bits
    logic        go_r,      go_nxt;       // Go flag
    logic        flag_r,    flag_nxt;     // conversion_complete_flag
    logic        on_r,      on_nxt;       // converter_on
    logic [1:0]  pcfg_r,    pcfg_nxt;     // port_config_select
    logic [7:0]  result_r,  result_nxt;   // conversion_result
    sac_state_t  state_r,   state_nxt;    // Sequencer state
    logic [4:0]  half_r,    half_nxt;     // Half periods in this phase
    logic [3:0]  div_r,     div_nxt;      // Core clock divider
    logic [7:0]  sar_r,     sar_nxt;      // Trial register
    logic [2:0]  bitidx_r,  bitidx_nxt;   // Bit under trial
    logic [31:0] prdata_nxt;              // Read data to be registered
    logic        pready_nxt;              // Answer strobe to be registered
    logic        pslverr_nxt;             // Error flag to be registered
    sac_afe_t    afe_nxt;                 // Front-end controls to be registered
    logic        flag_out_nxt;            // Flag copy for the output
    logic        busy_nxt;                // Busy copy for the output

    // Combinational helpers
    logic        acc;           // Access phase of an APB transfer
    logic        fire;          // Transfer completes on this edge
    logic        wr_main;       // Write to the main control register
    logic        wr_cfg;        // Write to the port config register
    logic        wr_res;        // Write to the result register
    logic        mapped;        // Address hits a register
    logic        half_tick;     // One half bit period has passed
    logic        done;          // Conversion completes on this edge
    logic [7:0]  main_rd;       // Read view of the main register

    // ****************************************************************
    // Bus decode
    // ****************************************************************

    // Answer comes one cycle into the access phase, from a flop
    always_comb begin
        acc     = psel && penable;
        fire    = acc && pready;
        mapped  = (paddr == SAC_ADDR_PORT) || (paddr == SAC_ADDR_MAIN) ||
                  (paddr == SAC_ADDR_RESULT) || (paddr == SAC_ADDR_CONFIG);
        wr_main = fire && pwrite && (paddr == SAC_ADDR_MAIN);
        wr_cfg  = fire && pwrite && (paddr == SAC_ADDR_CONFIG);
        wr_res  = fire && pwrite && (paddr == SAC_ADDR_RESULT);
        main_rd = {clksel_r, bit5_r, chs_r, go_r, flag_r, on_r};
    end

    // ****************************************************************
    // Conversion clock
    // ****************************************************************

    // Core-derived ticks stop in sleep; only the RC source keeps running
    always_comb begin
        div_nxt   = div_r;
        half_tick = 1'b0;
        if (state_r == SAC_OFF) begin
            div_nxt = 4'h0;                               // Quiet when off
        end else if (state_r == SAC_ACQ && go_r && clksel_r != SAC_CLK_RC) begin
            // Restart the divider at the start so a conversion spans 9.5 periods
            // The RC source runs free, so there it may end up to half a period early
            div_nxt = 4'h0;
        end else if (clksel_r == SAC_CLK_RC) begin
            half_tick = i_rc_half_tick;                   // Runs in sleep
            div_nxt   = 4'h0;
        end else if (!i_sleep) begin
            div_nxt   = div_r + 4'h1;
            half_tick = (div_nxt == half_div(clksel_r));
            if (half_tick) begin
                div_nxt = 4'h0;
            end
        end
    end

    // ****************************************************************
    // Sequencer and control registers
    // ****************************************************************

    // Hardware completion wins over a same-cycle software write of the flag
    always_comb begin
        clksel_nxt = clksel_r;
        bit5_nxt   = bit5_r;
        chs_nxt    = chs_r;
        go_nxt     = go_r;
        flag_nxt   = flag_r;
        on_nxt     = on_r;
        pcfg_nxt   = pcfg_r;
        result_nxt = result_r;
        state_nxt  = state_r;
        half_nxt   = half_r;
        sar_nxt    = sar_r;
        bitidx_nxt = bitidx_r;
        done       = 1'b0;

        // Software writes
        if (wr_main) begin
            clksel_nxt = pwdata[SAC_CLKSEL_HI:SAC_CLKSEL_LO];
            bit5_nxt   = (GP_BIT5 || CHS_3BIT) && pwdata[SAC_BIT5];
            chs_nxt    = pwdata[SAC_CHS_HI:SAC_CHS_LO];
            flag_nxt   = pwdata[SAC_FLAG];
            on_nxt     = pwdata[SAC_ON];
            // Start only if already on before this write
            if (pwdata[SAC_GO] && on_r && pwdata[SAC_ON]) begin
                go_nxt = 1'b1;
            end else if (!pwdata[SAC_GO]) begin
                go_nxt = 1'b0;
            end
        end
        if (wr_cfg) begin
            pcfg_nxt = pwdata[SAC_PCFG_HI:SAC_PCFG_LO];
        end
        if (wr_res) begin
            result_nxt = pwdata[7:0];
        end

        // Sequencer
        case (state_r)
            SAC_OFF: begin
                go_nxt   = 1'b0;
                half_nxt = 5'h00;
                if (on_r) begin
                    state_nxt = SAC_ACQ;
                end
            end
            SAC_ACQ: begin
                half_nxt = 5'h00;
                if (go_r) begin
                    state_nxt  = SAC_CONV;
                    sar_nxt    = 8'h80;                // MSB trial first
                    bitidx_nxt = 3'h7;
                end
            end
            SAC_CONV: begin
                if (!go_nxt) begin
                    state_nxt = SAC_GAP;               // Abort, result kept
                    half_nxt  = 5'h00;
                end else if (half_tick) begin
                    half_nxt = half_r + 5'h01;
                    // Each bit closes on every second half period
                    if (half_nxt > SAC_HALF_SETUP && !half_nxt[0]) begin
                        if (!i_cmp_high) begin
                            sar_nxt[bitidx_r] = 1'b0;
                        end
                        if (bitidx_r != 3'h0) begin
                            sar_nxt[bitidx_r - 3'h1] = 1'b1;
                            bitidx_nxt = bitidx_r - 3'h1;
                        end
                    end
                    if (half_nxt == SAC_HALF_CONV) begin
                        done       = 1'b1;
                        result_nxt = sar_nxt;
                        go_nxt     = 1'b0;
                        flag_nxt   = 1'b1;
                        state_nxt  = SAC_GAP;
                        half_nxt   = 5'h00;
                    end
                end
            end
            SAC_GAP: begin
                if (half_tick) begin
                    half_nxt = half_r + 5'h01;
                    if (half_nxt == SAC_HALF_GAP) begin
                        state_nxt = SAC_ACQ;           // Reacquire
                        half_nxt  = 5'h00;
                    end
                end
            end
            default: begin
                state_nxt = SAC_OFF;
            end
        endcase

        // Power-off shuts everything down at once
        if (!on_nxt) begin
            state_nxt = SAC_OFF;
            go_nxt    = 1'b0;
            half_nxt  = 5'h00;
        end
    end

    // ****************************************************************
    // Output and bus answer
    // ****************************************************************

    // All outputs are registered; bus answer from the current state, front end and status copies of the next state
    always_comb begin
        pready_nxt  = acc && !pready;
        pslverr_nxt = acc && !pready && !mapped;
        prdata_nxt  = 32'h0000_0000;
        if (acc && !pready && !pwrite) begin
            if (paddr == SAC_ADDR_MAIN) begin
                prdata_nxt[7:0] = main_rd;
            end else if (paddr == SAC_ADDR_CONFIG) begin
                prdata_nxt[1:0] = pcfg_r;
            end else if (paddr == SAC_ADDR_RESULT) begin
                prdata_nxt[7:0] = result_r;
            end else if (paddr == SAC_ADDR_PORT) begin
                prdata_nxt[3:0] = i_port_pins & ~analog_pins(pcfg_r);
            end
        end
        afe_nxt.power_on    = on_nxt;
        afe_nxt.sample      = (state_nxt == SAC_ACQ);
        afe_nxt.ref_ext     = (pcfg_nxt == 2'h1);
        afe_nxt.channel     = chs_nxt;
        afe_nxt.dac_code    = (state_nxt == SAC_CONV) ? sar_nxt : 8'h00;
        afe_nxt.analog_mask = analog_pins(pcfg_nxt);
        flag_out_nxt        = flag_nxt;                             // Request level
        busy_nxt            = go_nxt;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************

    // Synchronous reset; all control bits come up zero
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            clksel_r        <= SAC_MAIN_RST[7:6];
            bit5_r          <= SAC_MAIN_RST[5];
            chs_r           <= SAC_MAIN_RST[4:3];
            go_r            <= SAC_MAIN_RST[2];
            flag_r          <= SAC_MAIN_RST[1];
            on_r            <= SAC_MAIN_RST[0];
            pcfg_r          <= SAC_PCFG_RST;
            result_r        <= SAC_RESULT_RST;
            state_r         <= SAC_OFF;
            half_r          <= 5'h00;
            div_r           <= 4'h0;
            sar_r           <= 8'h00;
            bitidx_r        <= 3'h7;
            prdata          <= 32'h0000_0000;
            pready          <= 1'b0;
            pslverr         <= 1'b0;
            o_afe           <= '0;
            o_complete_flag <= 1'b0;
            o_busy          <= 1'b0;
        end else begin
            clksel_r        <= clksel_nxt;
            bit5_r          <= bit5_nxt;
            chs_r           <= chs_nxt;
            go_r            <= go_nxt;
            flag_r          <= flag_nxt;
            on_r            <= on_nxt;
            pcfg_r          <= pcfg_nxt;
            result_r        <= result_nxt;
            state_r         <= state_nxt;
            half_r          <= half_nxt;
            div_r           <= div_nxt;
            sar_r           <= sar_nxt;
            bitidx_r        <= bitidx_nxt;
            prdata          <= prdata_nxt;
            pready          <= pready_nxt;
            pslverr         <= pslverr_nxt;
            o_afe           <= afe_nxt;
            o_complete_flag <= flag_out_nxt;
            o_busy          <= busy_nxt;
        end
    end

endmodule

`default_nettype wire

/* File: tb/sac_adc_ctrl_asserts.sv */
// Checker of the converter control block as seen at its ports
`timescale 1ns/10ps
`default_nettype none
module sac_adc_asserts (
    // Clock, reset and bus
    input wire logic              i_clk,
    input wire logic              i_reset,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    // Front end and status
    input wire sac_pkg::sac_afe_t o_afe,
    input wire logic              o_complete_flag,
    input wire logic              o_busy
);
    import sac_pkg::*;
    // ****************************************
    // Clocking and helpers
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic wr_taken;  // Write taken at this edge
    assign wr_taken = psel && penable && pready && pwrite;
    // End of a conversion or an abort, converter still on
    sequence s_done;
        $fell(o_busy) && o_afe.power_on;
    endsequence
    // Hold capacitor kept off the channel for two /2 bit periods
    sequence s_gap;
        !o_afe.sample [*4];
    endsequence
    // ****************************************
    // Assertions
    // ****************************************
    AST_OFF_IDLE: assert property (!o_afe.power_on && !$past(o_afe.power_on)
        |-> !o_busy && !o_afe.sample && o_afe.dac_code == 8'h00)
        else $error("converter off but front end active");
    AST_GO_NEEDS_ON: assert property ($rose(o_busy) |-> $past(o_afe.power_on))
        else $error("conversion started while converter was off");
    AST_DONE_STEP: assert property ($rose(o_complete_flag) && !$past(wr_taken)
        |-> $fell(o_busy))
        else $error("flag set without go clearing in the same step");
    AST_FLAG_STICKY: assert property (o_complete_flag && !wr_taken |=> o_complete_flag)
        else $error("completion flag cleared by hardware");
    AST_GAP: assert property (s_done |-> s_gap)
        else $error("acquisition restarted too soon");
    AST_HOLD_IN_CONV: assert property (o_busy && $past(o_busy) |-> !o_afe.sample)
        else $error("hold capacitor tracking during conversion");
    AST_DAC_IDLE: assert property (!o_busy && !$past(o_busy) |-> o_afe.dac_code == 8'h00)
        else $error("trial code present outside conversion");
    AST_PIN_MAP: assert property (o_afe.analog_mask inside {4'hF, 4'h7, 4'h3, 4'h0}
        && (o_afe.ref_ext == (o_afe.analog_mask == 4'h7)))
        else $error("pin use does not match a configuration");
    AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
endmodule
bind sac_adc_ctrl sac_adc_asserts chk_u (.i_clk(i_clk), .i_reset(i_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .o_afe(o_afe),
    .o_complete_flag(o_complete_flag), .o_busy(o_busy));
`default_nettype wire

/* File: tb/sac_afe_model.sv */
// Model of the analog inputs and comparator beside the converter
`timescale 1ns/10ps
`default_nettype none
module sac_afe_model (
    // Clock and front-end control
    input  wire logic              i_clk,
    input  wire sac_pkg::sac_afe_t i_afe,
    // Input level of each channel, one byte each
    input  wire logic [31:0]       i_levels,
    output logic                   o_cmp_high
);
    import sac_pkg::*;
    logic tog_r = 1'b0;  // Junk pattern while unpowered
    // Unpowered comparator gives no settled answer
    always_ff @(posedge i_clk) begin
        tog_r <= !tog_r;
    end
    // Compare selected level against the trial code
    always_comb begin
        if (i_afe.power_on) begin
            o_cmp_high = i_levels[{i_afe.channel, 3'b000} +: 8] >= i_afe.dac_code;
        end else begin
            o_cmp_high = tog_r;
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Register-level testbench of the converter control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import sac_pkg::*;
    logic i_clk, i_reset, psel, penable, pwrite, pready, pslverr, i_sleep, i_rc_half_tick;
    logic o_complete_flag, o_busy, i_cmp_high, re;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic [3:0]  i_port_pins = 4'hF;
    logic [1:0]  tick_r = 2'h0;
    sac_afe_t    o_afe;
    int checks = 0, fails = 0;
    int per[4] = '{2, 8, 32, 8};  // Bit period in core clocks per clock code
    localparam logic [31:0] LEVELS = 32'h5AA5_FF00;  // Channel 3..0 levels
    sac_adc_ctrl dut_u (.i_clk(i_clk), .i_reset(i_reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_sleep(i_sleep), .i_rc_half_tick(i_rc_half_tick),
        .i_cmp_high(i_cmp_high), .i_port_pins(i_port_pins), .o_afe(o_afe),
        .o_complete_flag(o_complete_flag), .o_busy(o_busy));
    sac_afe_model afe_u (.i_clk(i_clk), .i_afe(o_afe), .i_levels(LEVELS),
        .o_cmp_high(i_cmp_high));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // RC half tick every four core clocks, so an RC bit period is 8 clocks
    always @(posedge i_clk) begin
        tick_r <= tick_r + 2'h1;
        i_rc_half_tick <= (tick_r == 2'h3);
    end
    // One APB transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin @(posedge i_clk); end while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, exp, rq);
    endtask
    task automatic finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard, far above the expected run of somewhat over a thousand cycles
    initial begin
        #200000;
        fails++;
        finish_test();
    end
    initial begin
        logic [7:0] m;
        int n;
        int c;
        i_reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        i_sleep = 1'b0;
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        // Reset values, unused bits, unmapped place
        rd("main", SAC_ADDR_MAIN, 32'h0000_0000);
        apb(1'b1, SAC_ADDR_CONFIG, 32'h0000_00FF);
        rd("config", SAC_ADDR_CONFIG, 32'h0000_0003);
        apb(1'b0, 12'h0F0, 32'h0000_0000);
        chk("slverr", 32'h1, {31'h0, re});
        apb(1'b1, SAC_ADDR_MAIN, 32'h0000_0020);
        rd("bit5", SAC_ADDR_MAIN, 32'h0000_0020);
        // Go ignored while off, and in the write that powers on
        apb(1'b1, SAC_ADDR_MAIN, 32'h0000_0004);
        rd("go_off", SAC_ADDR_MAIN, 32'h0000_0000);
        apb(1'b1, SAC_ADDR_MAIN, 32'h0000_0005);
        rd("go_on", SAC_ADDR_MAIN, 32'h0000_0001);
        $display("test registers done");
        // Pin use for each port configuration, pins all high
        for (c = 0; c < 4; c++) begin
            apb(1'b1, SAC_ADDR_CONFIG, c);
            rd("port", SAC_ADDR_PORT, (32'h0000_FC80 >> (c * 4)) & 32'hF);
            chk("ref_ext", (c == 1), o_afe.ref_ext);
        end
        apb(1'b1, SAC_ADDR_CONFIG, 32'h0000_0000); // All analog, pins kept as inputs
        $display("test pins done");
        // Conversion on each channel, channel c with clock code c, RC one asleep
        for (c = 0; c < 4; c++) begin
            m = {c[1:0], 1'b0, c[1:0], 3'b001};
            apb(1'b1, SAC_ADDR_MAIN, m);
            repeat (80) @(posedge i_clk);  // Acquisition and previous gap
            i_sleep <= (c == 3);
            // Free-running RC clock: start one edge after its tick, fixing the phase
            do begin @(posedge i_clk); end while (c == 3 && i_rc_half_tick !== 1'b1);
            apb(1'b1, SAC_ADDR_MAIN, m | 8'h04); // Go in a later write than power-on
            n = 0;
            do begin @(posedge i_clk); n++; end while (o_busy === 1'b1 && n < 2000);
            i_sleep <= 1'b0;
            chk("conv_len", 1, (n >= 19 * per[c] / 2) && (n <= 19 * per[c] / 2 + per[c]));
            rd("result", SAC_ADDR_RESULT, LEVELS[c * 8 +: 8]);
            rd("done", SAC_ADDR_MAIN, m | 8'h02);
            chk("flag", 1, o_complete_flag);
            apb(1'b1, SAC_ADDR_MAIN, m); // Flag cleared before the next run
            rd("cleared", SAC_ADDR_MAIN, m);
        end
        $display("test conversions done");
        // Abort keeps last result, then power off mid-conversion
        apb(1'b1, SAC_ADDR_MAIN, 32'h0000_0051);
        repeat (80) @(posedge i_clk);
        apb(1'b1, SAC_ADDR_MAIN, 32'h0000_0055);
        repeat (10) @(posedge i_clk);
        apb(1'b1, SAC_ADDR_MAIN, 32'h0000_0051);
        rd("abort", SAC_ADDR_MAIN, 32'h0000_0051);
        rd("kept", SAC_ADDR_RESULT, 32'h0000_005A);
        repeat (80) @(posedge i_clk);
        apb(1'b1, SAC_ADDR_MAIN, 32'h0000_0055);
        apb(1'b1, SAC_ADDR_MAIN, 32'h0000_0000);
        rd("off", SAC_ADDR_MAIN, 32'h0000_0000);
        chk("power", 0, o_afe.power_on);
        $display("test abort done");
        finish_test();
    end
endmodule
`default_nettype wire
